// *** core/pcrc_pkg.sv ***
// constants, register map and types of the programmable crc generator
// Function
// - taps program terms 15..1, length field separate
// - length field holds polynomial degree minus one
// - constant term and top term always implied
// - data word is length field plus one bits
// - start bit runs shifter, clearing it stops
// - queue depth eight above length seven, else sixteen
// - queue accepts single byte writes
// - write reaching top byte adds one word
// - shift while started and words queued, drain down
// - one bit per clock cycle
// - full flag when count equals depth
// - empty flag when count is zero
// - write while full wraps count, no interrupt
// - interrupt only on count one to zero
// - sixteen bit example uses length fifteen, taps 12,5
// - stop in idle freezes like sleep
// - sleep freezes shifter, resumes where it stopped
package pcrc_pkg;

    localparam int DATA_W = 16;
    localparam int LEN_W = 4;
    localparam int CNT_W = 5;
    localparam int PTR_W = 4;
    localparam int QUEUE_SLOTS = 16;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TAP = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0c;

    // control register layout
    localparam int CTRL_IDLE_BIT = 13;
    localparam int CTRL_CNT_LSB = 8;
    localparam int CTRL_FULL_BIT = 7;
    localparam int CTRL_EMPTY_BIT = 6;
    localparam int CTRL_START_BIT = 4;
    localparam int CTRL_LEN_LSB = 0;

    // queue sizing
    localparam logic [CNT_W-1:0] DEPTH_LONG = 5'h08;
    localparam logic [CNT_W-1:0] DEPTH_SHORT = 5'h10;
    localparam logic [LEN_W-1:0] LEN_SHORT_MAX = 4'h7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
    localparam logic [LEN_W-1:0] IDX_ZERO = 4'h0;
    localparam logic [LEN_W-1:0] IDX_ONE = 4'h1;

    // polynomial terms
    localparam logic [DATA_W-1:0] TAP_MASK = 16'hfffe;
    localparam logic [DATA_W-1:0] CONST_TERM = 16'h0001;
    localparam logic [LEN_W-1:0] EXAMPLE_LEN = 4'hf;
    localparam logic [DATA_W-1:0] EXAMPLE_TAPS = 16'h1020;

    // reset values
    localparam logic [LEN_W-1:0] RST_LEN = 4'h0;
    localparam logic [DATA_W-1:0] RST_TAP = 16'h0000;
    localparam logic [DATA_W-1:0] RST_RESULT = 16'h0000;
    localparam logic [DATA_W-1:0] RST_STAGE = 16'h0000;

    // ahb-lite encodings
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [3:0] BE_BYTE0 = 4'h1;
    localparam logic [3:0] BE_LO_HALF = 4'h3;
    localparam logic [3:0] BE_HI_HALF = 4'hc;
    localparam logic [3:0] BE_WORD = 4'hf;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PCRC_ST_IDLE = 2'b00,
        PCRC_ST_SHIFT = 2'b01,
        PCRC_ST_HOLD = 2'b11
    } pcrc_state_type;

endpackage : pcrc_pkg

// *** core/pcrc_q_if.sv ***
// bundle between the crc controller and its input queue
`timescale 1ns/1ps
interface pcrc_q_if;
    logic push;
    logic clear;
    logic pop;
    logic [pcrc_pkg::DATA_W-1:0] wdata;
    logic [pcrc_pkg::CNT_W-1:0] depth;
    logic [pcrc_pkg::DATA_W-1:0] rdata;
    logic [pcrc_pkg::CNT_W-1:0] count;
    logic full;
    logic empty;

    modport ctl (output push, output clear, output pop, output wdata, output depth,
                 input rdata, input count, input full, input empty);
    modport store (input push, input clear, input pop, input wdata, input depth,
                   output rdata, output count, output full, output empty);
endinterface : pcrc_q_if

// *** core/pcrc_fifo.sv ***
// input queue of the crc generator with its valid word count
`timescale 1ns/1ps
module pcrc_fifo (
    input wire logic clk,
    input wire logic rstn,
    pcrc_q_if.store q
);

    logic [pcrc_pkg::DATA_W-1:0] mem [0:pcrc_pkg::QUEUE_SLOTS-1];
    logic [pcrc_pkg::PTR_W-1:0] wr_ptr;
    logic [pcrc_pkg::PTR_W-1:0] rd_ptr;
    logic [pcrc_pkg::CNT_W-1:0] count;
    logic [pcrc_pkg::CNT_W-1:0] next_count;

    // pointers wrap at sixteen; with depth eight the count never lets them lap
    wire do_push = q.push & ~q.clear;
    wire do_pop = q.pop & ~q.clear & (count != pcrc_pkg::CNT_ZERO);

    assign next_count = count + {{(pcrc_pkg::CNT_W-1){1'b0}}, do_push} - {{(pcrc_pkg::CNT_W-1){1'b0}}, do_pop};

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= q.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= pcrc_pkg::PTR_ZERO;
            rd_ptr <= pcrc_pkg::PTR_ZERO;
            count <= pcrc_pkg::CNT_ZERO;
        end else if (q.clear) begin
            wr_ptr <= pcrc_pkg::PTR_ZERO;
            rd_ptr <= pcrc_pkg::PTR_ZERO;
            count <= pcrc_pkg::CNT_ZERO;
        end else begin
            wr_ptr <= do_push ? wr_ptr + pcrc_pkg::PTR_ONE : wr_ptr;
            rd_ptr <= do_pop ? rd_ptr + pcrc_pkg::PTR_ONE : rd_ptr;
            count <= next_count;
        end
    end

    assign q.rdata = mem[rd_ptr];
    assign q.count = count;
    assign q.full = (count == q.depth);
    assign q.empty = (count == pcrc_pkg::CNT_ZERO);

endmodule : pcrc_fifo

// *** core/pcrc_lfsr.sv ***
// crc shift register with programmable taps and length
`timescale 1ns/1ps
module pcrc_lfsr (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [pcrc_pkg::DATA_W-1:0] load_value,
    input wire logic shift,
    input wire logic data_in,
    input wire logic [pcrc_pkg::LEN_W-1:0] poly_len,
    input wire logic [pcrc_pkg::DATA_W-1:0] taps,
    output logic [pcrc_pkg::DATA_W-1:0] crc
);

    logic [pcrc_pkg::DATA_W-1:0] len_mask;
    logic [pcrc_pkg::DATA_W-1:0] next_crc;

    genvar i;
    generate
        for (i = 0; i < pcrc_pkg::DATA_W; i = i + 1) begin : g_mask
            assign len_mask[i] = (i <= poly_len);
        end
    endgenerate

    // the bit shifted out stands for the top term, so it needs no tap bit
    wire feedback = data_in ^ crc[poly_len];
    wire [pcrc_pkg::DATA_W-1:0] poly = (taps | pcrc_pkg::CONST_TERM) & len_mask;
    wire [pcrc_pkg::DATA_W-1:0] shifted = {crc[pcrc_pkg::DATA_W-2:0], 1'b0} & len_mask;

    assign next_crc = feedback ? (shifted ^ poly) : shifted;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc <= pcrc_pkg::RST_RESULT;
        end else if (load) begin
            crc <= load_value;
        end else if (shift) begin
            crc <= next_crc;
        end
    end

endmodule : pcrc_lfsr

// *** core/pcrc_top.sv ***
// programmable crc generator with input queue behind an ahb-lite slave
`timescale 1ns/1ps
module pcrc_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    output logic crc_drain_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    pcrc_q_if q ();

    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [3:0] dp_be;

    logic shift_start_bit;
    logic stop_in_idle_bit;
    logic [pcrc_pkg::LEN_W-1:0] poly_len_field;
    logic [pcrc_pkg::DATA_W-1:0] poly_tap_register;
    logic [pcrc_pkg::DATA_W-1:0] stage;
    logic [pcrc_pkg::DATA_W-1:0] crc_value;
    logic [pcrc_pkg::LEN_W-1:0] bit_idx;
    logic [pcrc_pkg::LEN_W-1:0] next_bit_idx;

    pcrc_pkg::pcrc_state_type state;
    pcrc_pkg::pcrc_state_type next_state;

    logic [31:0] read_mux;

    ////////////////////////////////////////////////////////////////////////////////
    // byte lane merge for partial writes

    function automatic logic [15:0] pcrc_merge(
        input logic [15:0] old_value,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] merged;
        merged = old_value;
        if (be[0]) begin
            merged[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merged[15:8] = wd[15:8];
        end
        return merged;
    endfunction : pcrc_merge

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase

    wire access = hsel & hready & htrans[pcrc_pkg::HTRANS_ACTIVE_BIT];
    wire [3:0] be_byte = pcrc_pkg::BE_BYTE0 << haddr[1:0];
    wire [3:0] be_half = haddr[1] ? pcrc_pkg::BE_HI_HALF : pcrc_pkg::BE_LO_HALF;
    wire [3:0] be_now = (hsize == pcrc_pkg::HSIZE_BYTE) ? be_byte :
                        (hsize == pcrc_pkg::HSIZE_HALF) ? be_half : pcrc_pkg::BE_WORD;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            dp_be <= pcrc_pkg::BE_NONE;
        end else begin
            dp_valid <= access;
            dp_write <= access & hwrite;
            // byte and halfword writes land on the word that holds them; reads decode the full byte address
            dp_addr <= {haddr[7:2], 2'b00};
            dp_be <= access ? be_now : pcrc_pkg::BE_NONE;
        end
    end

    // no wait states, so the slave never stalls the bus
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // data phase write decode

    wire wr_any = dp_valid & dp_write;
    wire wr_ctrl = wr_any & (dp_addr == pcrc_pkg::OFS_CTRL);
    wire wr_tap = wr_any & (dp_addr == pcrc_pkg::OFS_TAP);
    wire wr_result = wr_any & (dp_addr == pcrc_pkg::OFS_RESULT);
    wire wr_wdata = wr_any & (dp_addr == pcrc_pkg::OFS_WDATA);

    wire long_word = (poly_len_field > pcrc_pkg::LEN_SHORT_MAX);
    // the top byte of a word is lane one for lengths above eight bits
    wire top_lane_hit = long_word ? dp_be[1] : dp_be[0];
    wire [pcrc_pkg::DATA_W-1:0] stage_merged = pcrc_merge(stage, hwdata, dp_be);
    wire word_done = wr_wdata & top_lane_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // control and configuration registers

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift_start_bit <= 1'b0;
            poly_len_field <= pcrc_pkg::RST_LEN;
        end else if (wr_ctrl & dp_be[0]) begin
            shift_start_bit <= hwdata[pcrc_pkg::CTRL_START_BIT];
            poly_len_field <= hwdata[pcrc_pkg::CTRL_LEN_LSB +: pcrc_pkg::LEN_W];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_in_idle_bit <= 1'b0;
        end else if (wr_ctrl & dp_be[1]) begin
            stop_in_idle_bit <= hwdata[pcrc_pkg::CTRL_IDLE_BIT];
        end
    end

    // bit zero of the tap register is not stored and reads as zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            poly_tap_register <= pcrc_pkg::RST_TAP;
        end else if (wr_tap) begin
            poly_tap_register <= pcrc_merge(poly_tap_register, hwdata, dp_be) & pcrc_pkg::TAP_MASK;
        end
    end

    // partial bytes gather here until the top byte completes the word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage <= pcrc_pkg::RST_STAGE;
        end else if (wr_wdata) begin
            stage <= stage_merged;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // input queue

    wire wrap = word_done & q.full;

    assign q.depth = long_word ? pcrc_pkg::DEPTH_LONG : pcrc_pkg::DEPTH_SHORT;
    assign q.push = word_done;
    assign q.clear = wrap;
    assign q.wdata = stage_merged;

    pcrc_fifo u_fifo (
        .clk(clk),
        .rstn(rstn),
        .q(q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // shifter sequencing

    // clocks stop in sleep, and in idle when asked to; state is simply held
    wire run_ok = ~sleep_mode & ~(idle_mode & stop_in_idle_bit);
    wire go = shift_start_bit & ~q.empty & ~wrap;
    wire shift_en = (state == pcrc_pkg::PCRC_ST_SHIFT) & go & run_ok;
    wire last_bit = (bit_idx == poly_len_field);
    wire pop = shift_en & last_bit;
    wire [pcrc_pkg::LEN_W-1:0] data_pos = poly_len_field - bit_idx;
    wire data_bit = q.rdata[data_pos];

    assign q.pop = pop;

    always_comb begin
        next_state = state;
        unique case (state)
            pcrc_pkg::PCRC_ST_IDLE: begin
                if (go) begin
                    next_state = run_ok ? pcrc_pkg::PCRC_ST_SHIFT : pcrc_pkg::PCRC_ST_HOLD;
                end
            end
            pcrc_pkg::PCRC_ST_SHIFT: begin
                if (!go) begin
                    next_state = pcrc_pkg::PCRC_ST_IDLE;
                end else if (!run_ok) begin
                    next_state = pcrc_pkg::PCRC_ST_HOLD;
                end else if (pop & (q.count == pcrc_pkg::CNT_ONE) & ~word_done) begin
                    next_state = pcrc_pkg::PCRC_ST_IDLE;
                end
            end
            pcrc_pkg::PCRC_ST_HOLD: begin
                if (!go) begin
                    next_state = pcrc_pkg::PCRC_ST_IDLE;
                end else if (run_ok) begin
                    next_state = pcrc_pkg::PCRC_ST_SHIFT;
                end
            end
            default: begin
                next_state = pcrc_pkg::PCRC_ST_IDLE;
            end
        endcase
    end

    // clearing start abandons a half shifted word; a freeze keeps the position
    always_comb begin
        next_bit_idx = bit_idx;
        if (!shift_start_bit | wrap) begin
            next_bit_idx = pcrc_pkg::IDX_ZERO;
        end else if (pop) begin
            next_bit_idx = pcrc_pkg::IDX_ZERO;
        end else if (shift_en) begin
            next_bit_idx = bit_idx + pcrc_pkg::IDX_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= pcrc_pkg::PCRC_ST_IDLE;
            bit_idx <= pcrc_pkg::IDX_ZERO;
        end else begin
            state <= next_state;
            bit_idx <= next_bit_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crc engine

    // a software preset of the result wins over a shift in the same cycle
    pcrc_lfsr u_lfsr (
        .clk(clk),
        .rstn(rstn),
        .load(wr_result),
        .load_value(pcrc_merge(crc_value, hwdata, dp_be)),
        .shift(shift_en),
        .data_in(data_bit),
        .poly_len(poly_len_field),
        .taps(poly_tap_register),
        .crc(crc_value)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // drain interrupt

    // a wrap empties the queue without the one to zero step, so it stays quiet
    wire drain_event = pop & (q.count == pcrc_pkg::CNT_ONE) & ~word_done;

    // not gated by the freeze so a pending event still leaves the block
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_drain_irq <= 1'b0;
        end else begin
            crc_drain_irq <= drain_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    wire [pcrc_pkg::DATA_W-1:0] ctrl_view = {2'b00,
                                             stop_in_idle_bit,
                                             q.count,
                                             q.full,
                                             q.empty,
                                             1'b0,
                                             shift_start_bit,
                                             poly_len_field};

    wire rd_ctrl = (haddr[7:0] == pcrc_pkg::OFS_CTRL);
    wire rd_tap = (haddr[7:0] == pcrc_pkg::OFS_TAP);
    // the result only means something once the queue has drained
    wire rd_result = (haddr[7:0] == pcrc_pkg::OFS_RESULT) | (haddr[7:0] == pcrc_pkg::OFS_WDATA);

    assign read_mux = rd_ctrl ? {16'h0000, ctrl_view} :
                      rd_tap ? {16'h0000, poly_tap_register} :
                      rd_result ? {16'h0000, crc_value} : pcrc_pkg::RDATA_ZERO;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= pcrc_pkg::RDATA_ZERO;
        end else if (access & ~hwrite) begin
            hrdata <= read_mux;
        end else begin
            hrdata <= pcrc_pkg::RDATA_ZERO;
        end
    end

endmodule : pcrc_top

// *** dv/pcrc_top_properties.sv ***
// concurrent checks on the bus-side and interrupt ports of the crc generator
`timescale 1ns/1ps
module pcrc_top_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic crc_drain_irq
);
    logic rd_q;
    logic [7:0] ofs_q;
    logic ctl_rd;
    logic [4:0] depth;

    // the length field comes back in the same read, so flags are judged against it
    assign ctl_rd = rd_q && (ofs_q == pcrc_pkg::OFS_CTRL);
    assign depth = (hrdata[3:0] > pcrc_pkg::LEN_SHORT_MAX) ? pcrc_pkg::DEPTH_LONG : pcrc_pkg::DEPTH_SHORT;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= 1'b0;
            ofs_q <= 8'h00;
        end else begin
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            ofs_q <= haddr[7:0];
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ready_always: assert property (hreadyout) else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0000_0000) else $error("hrdata outside data phase");
    a_empty_flag: assert property (ctl_rd |-> hrdata[6] == (hrdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    a_full_flag: assert property (ctl_rd |-> hrdata[7] == (hrdata[12:8] == depth))
        else $error("full flag disagrees with count");
    a_count_bound: assert property (ctl_rd |-> hrdata[12:8] <= depth)
        else $error("count above queue depth");
    a_ctl_reserved: assert property (ctl_rd |-> hrdata[31:14] == 18'h00000 && !hrdata[5])
        else $error("reserved control bits set");
    a_tap_bit_zero: assert property (rd_q && ofs_q == pcrc_pkg::OFS_TAP |-> !hrdata[0])
        else $error("tap bit zero reads one");
    a_irq_pulse: assert property (crc_drain_irq |=> !crc_drain_irq)
        else $error("drain interrupt longer than one cycle");
    a_reset_clean: assert property ($rose(rstn) |-> hrdata == 32'h0000_0000 && !crc_drain_irq)
        else $error("outputs not quiet after reset");
endmodule : pcrc_top_properties

bind pcrc_top pcrc_top_properties chk_u (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .idle_mode, .sleep_mode, .crc_drain_irq);

// *** dv/pcrc_top_tb.sv ***
// self-checking bench for the programmable crc generator
`timescale 1ns/1ps
module pcrc_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic idle_mode = 1'b0;
    logic sleep_mode = 1'b0;
    logic crc_drain_irq;
    int fail_count = 0;
    int n_checks = 0;

    always #2.5 clk = ~clk;

    pcrc_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .crc_drain_irq(crc_drain_irq));

    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_ready

    // one single transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= sz;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, 3'h2, d, x);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 3'h2, 32'h0000_0000, x);
        check(what, x, exp);
    endtask : rd_chk

    task automatic wait_irq(output int n);
        n = 0;
        while (crc_drain_irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_irq

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [3:0] len,
                                             input logic [15:0] taps, input logic [15:0] w);
        logic [15:0] m;
        logic fb;
        m = 16'hffff >> (4'hf - len);
        for (int i = 15; i >= 0; i--) begin
            if (i <= len) begin
                fb = w[i] ^ c[len];
                c = ((c << 1) & m) ^ (fb ? ((taps | 16'h0001) & m) : 16'h0000);
            end
        end
        return c;
    endfunction : crc_step

    function automatic logic [31:0] ctl_exp(input logic sii, input logic go, input logic [3:0] len,
                                            input logic [4:0] cnt);
        logic [4:0] dep;
        dep = (len > 4'h7) ? 5'h08 : 5'h10;
        return {18'h00000, sii, cnt, cnt == dep, cnt == 5'h00, 1'b0, go, len};
    endfunction : ctl_exp

    ////////////////////////////////////////
    // fz: 0 none, 1 sleep, 2 idle with stop-in-idle, 3 idle that must not stop
    task automatic run_case(input logic [3:0] len, input int nw, input int fz);
        logic [15:0] taps;
        logic [15:0] w;
        logic [15:0] exp_crc;
        logic sii;
        int n;
        taps = 16'($urandom) & 16'hfffe;
        sii = (fz == 2);
        exp_crc = 16'h0000;
        wr(8'h04, {16'h0000, taps});
        wr(8'h08, 32'h0000_0000);
        wr(8'h00, {18'h00000, sii, 9'h000, len});
        for (int k = 0; k < nw; k++) begin
            w = 16'($urandom) & (16'hffff >> (4'hf - len));
            exp_crc = crc_step(exp_crc, len, taps, w);
            wr(8'h0c, {16'h0000, w});
        end
        rd_chk("ctl queued", 8'h00, ctl_exp(sii, 1'b0, len, nw[4:0]));
        wr(8'h00, {18'h00000, sii, 9'h001, len});
        n = 0;
        while (crc_drain_irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
            if (n == 3) begin
                idle_mode <= (fz >= 2);
                sleep_mode <= (fz == 1);
            end
            if (n == 8) begin
                idle_mode <= 1'b0;
                sleep_mode <= 1'b0;
            end
        end
        // a freeze costs its own length plus one cycle to leave the hold state
        check("drain cycles", n, 2 + (len + 1) * nw + ((fz == 1 || fz == 2) ? 6 : 0));
        rd_chk("ctl drained", 8'h00, ctl_exp(sii, 1'b1, len, 5'h00));
        rd_chk("crc result", 8'h0c, {16'h0000, exp_crc});
        wr(8'h00, 32'h0000_0000);
    endtask : run_case

    initial begin
        logic [3:0] lens [4];
        logic [3:0] len;
        logic [31:0] x;
        logic [15:0] bw;
        int dep;
        int n;
        lens = '{4'h1, 4'h7, 4'h8, 4'hf};
        n = $urandom(37);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk("ctl reset", 8'h00, 32'h0000_0040);
        rd_chk("tap reset", 8'h04, 32'h0000_0000);
        rd_chk("result reset", 8'h08, 32'h0000_0000);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        wr(8'h04, 32'h0000_ffff);
        rd_chk("tap field", 8'h04, 32'h0000_fffe);
        wr(8'h00, 32'h0000_200f);
        rd_chk("ctl fields", 8'h00, ctl_exp(1'b1, 1'b0, 4'hf, 5'h00));
        for (int i = 0; i < 12; i++) begin
            len = (i < 4) ? lens[i] : 4'($urandom_range(15, 1));
            dep = (len > 4'h7) ? 8 : 16;
            run_case(len, (i < 4) ? dep : $urandom_range(dep, 4), i % 4);
        end
        // sixteen-bit word assembled from two byte writes
        bw = 16'($urandom);
        wr(8'h04, 32'h0000_1020);
        wr(8'h08, 32'h0000_0000);
        wr(8'h00, 32'h0000_000f);
        bus(1'b1, 8'h0c, 3'h0, {24'h000000, bw[7:0]}, x);
        rd_chk("low byte staged", 8'h00, ctl_exp(1'b0, 1'b0, 4'hf, 5'h00));
        bus(1'b1, 8'h0d, 3'h0, {16'h0000, bw[15:8], 8'h00}, x);
        rd_chk("top byte pushed", 8'h00, ctl_exp(1'b0, 1'b0, 4'hf, 5'h01));
        wr(8'h00, 32'h0000_001f);
        wait_irq(n);
        check("byte drain cycles", n, 18);
        rd_chk("example crc", 8'h0c, {16'h0000, crc_step(16'h0000, 4'hf, 16'h1020, bw)});
        // a write while full wraps the queue and must stay silent
        wr(8'h00, 32'h0000_0008);
        for (int k = 0; k < 8; k++) begin
            wr(8'h0c, 32'h0000_01a5);
        end
        rd_chk("queue full", 8'h00, ctl_exp(1'b0, 1'b0, 4'h8, 5'h08));
        wr(8'h0c, 32'h0000_005a);
        rd_chk("wrapped", 8'h00, ctl_exp(1'b0, 1'b0, 4'h8, 5'h00));
        wr(8'h00, 32'h0000_0018);
        wait_irq(n);
        check("no wrap irq", n, 400);
        // second reset in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk("ctl re-reset", 8'h00, 32'h0000_0040);
        rd_chk("tap re-reset", 8'h04, 32'h0000_0000);
        give_verdict();
    end

    initial begin
        #250000;
        fail_count++;
        give_verdict();
    end
endmodule : pcrc_top_tb
